// File: rtl/wdc_pkg.sv
package wdc_pkg;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0] WDC_CH5_HYST_OFS     = 8'h34;
   localparam logic [7:0] WDC_CH5_HIGH_OFS     = 8'h35;
   localparam logic [7:0] WDC_CH5_COUNT_OFS    = 8'h36;
   localparam logic [7:0] WDC_CH5_LOW_OFS      = 8'h37;
   localparam logic [7:0] WDC_CH6_HYST_OFS     = 8'h38;
   localparam logic [7:0] WDC_CH6_HIGH_OFS     = 8'h39;
   localparam logic [7:0] WDC_CH6_COUNT_OFS    = 8'h3a;
   localparam logic [7:0] WDC_CH6_LOW_OFS      = 8'h3b;
   localparam logic [7:0] WDC_CH_STRIDE        = 8'h04;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [7:0] WDC_HYST_RST         = 8'hf0;
   localparam logic [7:0] WDC_HIGH_RST         = 8'hff;
   localparam logic [7:0] WDC_COUNT_RST        = 8'h00;
   localparam logic [7:0] WDC_LOW_RST          = 8'h00;
   localparam logic [7:0] WDC_UNMAPPED_RD      = 8'h00;

   // ------------------------------------------------------------
   // field layout
   // ------------------------------------------------------------
   localparam int         WDC_NIB_HI_MSB       = 7;
   localparam int         WDC_NIB_HI_LSB       = 4;
   localparam int         WDC_NIB_LO_MSB       = 3;
   localparam int         WDC_NIB_LO_LSB       = 0;
   localparam int         WDC_SAMPLE_W         = 12;
   localparam int         WDC_HYST_SHIFT       = 3;
   localparam logic [2:0] WDC_CH5_SEL          = 3'h5;
   localparam logic [2:0] WDC_CH6_SEL          = 3'h6;
   localparam logic [3:0] WDC_COUNT_MAX        = 4'hf;

   // ------------------------------------------------------------
   // arithmetic helpers
   // ------------------------------------------------------------
   function automatic logic [11:0] wdc_sat_sub(input logic [11:0] a, input logic [6:0] b);
      logic [12:0] d;
      d = {1'b0, a} - {6'h00, b};
      wdc_sat_sub = d[12] ? 12'h000 : d[11:0];
   endfunction : wdc_sat_sub

   function automatic logic [11:0] wdc_sat_add(input logic [11:0] a, input logic [6:0] b);
      logic [12:0] s;
      s = {1'b0, a} + {6'h00, b};
      wdc_sat_add = s[12] ? 12'hfff : s[11:0];
   endfunction : wdc_sat_add

endpackage : wdc_pkg

// File: rtl/wdc_chan_cmp.sv
`timescale 1ns/1ns
module wdc_chan_cmp (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  hystRegVal,
   input  wire logic [7:0]  highRegVal,
   input  wire logic [7:0]  countRegVal,
   input  wire logic [7:0]  lowRegVal,
   input  wire logic        sampleStrobe,
   input  wire logic [11:0] sampleData,
   output logic             beyondState,
   output logic             eventSet
);

   // ------------------------------------------------------------
   // limit assembly
   // ------------------------------------------------------------
   logic [11:0] highLimit;
   logic [11:0] lowLimit;
   logic [6:0]  hystAmount;
   logic [3:0]  sampleCount;
   logic [11:0] highRelease;
   logic [11:0] lowRelease;
   logic        aboveNow;
   logic        belowNow;
   logic        beyondNow;
   logic        above_reg;
   logic        below_reg;
   logic [3:0]  run_reg;

   assign highLimit   = {highRegVal,
                         hystRegVal[wdc_pkg::WDC_NIB_HI_MSB:wdc_pkg::WDC_NIB_HI_LSB]};
   assign lowLimit    = {lowRegVal,
                         countRegVal[wdc_pkg::WDC_NIB_HI_MSB:wdc_pkg::WDC_NIB_HI_LSB]};
   assign hystAmount  = {hystRegVal[wdc_pkg::WDC_NIB_LO_MSB:wdc_pkg::WDC_NIB_LO_LSB],
                         3'h0};
   assign sampleCount = countRegVal[wdc_pkg::WDC_NIB_LO_MSB:wdc_pkg::WDC_NIB_LO_LSB];

   // ------------------------------------------------------------
   // window test with hysteresis
   // ------------------------------------------------------------
   assign highRelease = wdc_pkg::wdc_sat_sub(highLimit, hystAmount);
   assign lowRelease  = wdc_pkg::wdc_sat_add(lowLimit, hystAmount);
   assign aboveNow    = above_reg ? (sampleData > highRelease)
                                  : (sampleData > highLimit);
   assign belowNow    = below_reg ? (sampleData < lowRelease)
                                  : (sampleData < lowLimit);
   assign beyondNow   = aboveNow | belowNow;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         above_reg <= 1'b0;
         below_reg <= 1'b0;
      end else if (sampleStrobe) begin
         above_reg <= aboveNow;
         below_reg <= belowNow;
      end
   end

   // ------------------------------------------------------------
   // consecutive sample counter
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         run_reg <= 4'h0;
      end else if (sampleStrobe) begin
         if (!beyondNow) begin
            run_reg <= 4'h0;
         end else if (run_reg != wdc_pkg::WDC_COUNT_MAX) begin
            run_reg <= run_reg + 4'h1;
         end
      end
   end

   // fires on the (n+1)th consecutive beyond sample and after
   assign eventSet    = sampleStrobe & beyondNow & (run_reg >= sampleCount);
   assign beyondState = above_reg | below_reg;

endmodule : wdc_chan_cmp

// File: rtl/wdc_limits.sv
`timescale 1ns/1ns
module wdc_limits (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  regAddr,
   input  wire logic [7:0]  regWrData,
   input  wire logic        regWrEn,
   input  wire logic        regRdEn,
   output logic [7:0]       regRdData,
   output logic             regHit,
   input  wire logic        sampleValid,
   input  wire logic [2:0]  sampleChannel,
   input  wire logic [11:0] sampleData,
   input  wire logic [1:0]  eventClear,
   output logic [1:0]       eventFlag,
   output logic [1:0]       beyondState
);

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   logic [7:0] hyst_reg  [2];
   logic [7:0] high_reg  [2];
   logic [7:0] count_reg [2];
   logic [7:0] low_reg   [2];
   logic [7:0] rdData_reg;
   logic       hit_reg;
   logic [1:0] flag_reg;
   logic [1:0] eventSet;
   logic [1:0] chStrobe;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int c = 0; c < 2; c++) begin
            hyst_reg[c]  <= wdc_pkg::WDC_HYST_RST;
            high_reg[c]  <= wdc_pkg::WDC_HIGH_RST;
            count_reg[c] <= wdc_pkg::WDC_COUNT_RST;
            low_reg[c]   <= wdc_pkg::WDC_LOW_RST;
         end
      end else if (regWrEn) begin
         if (regAddr == wdc_pkg::WDC_CH5_HYST_OFS) begin
            hyst_reg[0] <= regWrData;
         end else if (regAddr == wdc_pkg::WDC_CH5_HIGH_OFS) begin
            high_reg[0] <= regWrData;
         end else if (regAddr == wdc_pkg::WDC_CH5_COUNT_OFS) begin
            count_reg[0] <= regWrData;
         end else if (regAddr == wdc_pkg::WDC_CH5_LOW_OFS) begin
            low_reg[0] <= regWrData;
         end else if (regAddr == wdc_pkg::WDC_CH6_HYST_OFS) begin
            hyst_reg[1] <= regWrData;
         end else if (regAddr == wdc_pkg::WDC_CH6_HIGH_OFS) begin
            high_reg[1] <= regWrData;
         end else if (regAddr == wdc_pkg::WDC_CH6_COUNT_OFS) begin
            count_reg[1] <= regWrData;
         end else if (regAddr == wdc_pkg::WDC_CH6_LOW_OFS) begin
            low_reg[1] <= regWrData;
         end
      end
   end

   // ------------------------------------------------------------
   // read port
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdData_reg <= wdc_pkg::WDC_UNMAPPED_RD;
         hit_reg    <= 1'b0;
      end else if (regRdEn) begin
         hit_reg <= 1'b1;
         if (regAddr == wdc_pkg::WDC_CH5_HYST_OFS) begin
            rdData_reg <= hyst_reg[0];
         end else if (regAddr == wdc_pkg::WDC_CH5_HIGH_OFS) begin
            rdData_reg <= high_reg[0];
         end else if (regAddr == wdc_pkg::WDC_CH5_COUNT_OFS) begin
            rdData_reg <= count_reg[0];
         end else if (regAddr == wdc_pkg::WDC_CH5_LOW_OFS) begin
            rdData_reg <= low_reg[0];
         end else if (regAddr == wdc_pkg::WDC_CH6_HYST_OFS) begin
            rdData_reg <= hyst_reg[1];
         end else if (regAddr == wdc_pkg::WDC_CH6_HIGH_OFS) begin
            rdData_reg <= high_reg[1];
         end else if (regAddr == wdc_pkg::WDC_CH6_COUNT_OFS) begin
            rdData_reg <= count_reg[1];
         end else if (regAddr == wdc_pkg::WDC_CH6_LOW_OFS) begin
            rdData_reg <= low_reg[1];
         end else begin
            rdData_reg <= wdc_pkg::WDC_UNMAPPED_RD;
            hit_reg    <= 1'b0;
         end
      end
   end

   assign regRdData = rdData_reg;
   assign regHit    = hit_reg;

   // ------------------------------------------------------------
   // per-channel comparators
   // ------------------------------------------------------------
   assign chStrobe[0] = sampleValid & (sampleChannel == wdc_pkg::WDC_CH5_SEL);
   assign chStrobe[1] = sampleValid & (sampleChannel == wdc_pkg::WDC_CH6_SEL);

   wdc_chan_cmp u_cmpCh5 (
      .clk          (clk),
      .sys_rst      (sys_rst),
      .hystRegVal   (hyst_reg[0]),
      .highRegVal   (high_reg[0]),
      .countRegVal  (count_reg[0]),
      .lowRegVal    (low_reg[0]),
      .sampleStrobe (chStrobe[0]),
      .sampleData   (sampleData),
      .beyondState  (beyondState[0]),
      .eventSet     (eventSet[0])
   );

   wdc_chan_cmp u_cmpCh6 (
      .clk          (clk),
      .sys_rst      (sys_rst),
      .hystRegVal   (hyst_reg[1]),
      .highRegVal   (high_reg[1]),
      .countRegVal  (count_reg[1]),
      .lowRegVal    (low_reg[1]),
      .sampleStrobe (chStrobe[1]),
      .sampleData   (sampleData),
      .beyondState  (beyondState[1]),
      .eventSet     (eventSet[1])
   );

   // ------------------------------------------------------------
   // sticky event flags, set beats clear
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         flag_reg <= 2'h0;
      end else begin
         flag_reg <= (flag_reg & ~eventClear) | eventSet;
      end
   end

   assign eventFlag = flag_reg;

endmodule : wdc_limits

// File: verif/wdc_limits_assertions.sv
`timescale 1ns/1ns
module wdc_limits_chk (
   input wire logic       clk,
   input wire logic       sys_rst,
   input wire logic [7:0] regAddr,
   input wire logic       regRdEn,
   input wire logic [7:0] regRdData,
   input wire logic       regHit,
   input wire logic       sampleValid,
   input wire logic [2:0] sampleChannel,
   input wire logic [1:0] eventClear,
   input wire logic [1:0] eventFlag,
   input wire logic [1:0] beyondState
);
   // ------------------------------
   // watched relations
   // ------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   wire logic inMap = regAddr >= 8'h34 && regAddr <= 8'h3b;
   wire logic rdMiss = regRdEn && !inMap;
   wire logic s5    = sampleValid && sampleChannel == 3'h5;
   wire logic s56   = s5 || (sampleValid && sampleChannel == 3'h6);
   a_unmapped_read_zero: assert property (rdMiss |=> regRdData == 8'h00 && !regHit)
      else $error("unmapped read gave data or hit");
   a_mapped_read_hit: assert property (regRdEn && inMap |=> regHit)
      else $error("mapped read without hit");
   a_read_data_hold: assert property (!regRdEn |=> $stable(regRdData) && $stable(regHit))
      else $error("read data moved without a read");
   a_flag_stays_set: assert property (eventFlag[0] && !eventClear[0] |=> eventFlag[0])
      else $error("event flag dropped without clear");
   a_clear_drops_flag: assert property (eventClear[0] && !s5 |=> !eventFlag[0])
      else $error("event flag survived clear");
   a_rise_after_sample: assert property ($rose(eventFlag[0]) |-> $past(s5))
      else $error("event flag rose without a sample");
   a_rise_when_beyond: assert property ($rose(eventFlag[0]) |-> beyondState[0])
      else $error("event flag rose inside window");
   a_other_chan_ignored: assert property (!s56 |=> $stable(beyondState))
      else $error("window state moved without a sample");
   cover property ($rose(eventFlag[1]));
   cover property (regRdEn && !inMap);
   cover property ($fell(beyondState[0]));
   cover property (eventClear[1] && sampleValid && sampleChannel == 3'h6 ##1 eventFlag[1]);
endmodule : wdc_limits_chk

bind wdc_limits wdc_limits_chk chk_u (.clk, .sys_rst, .regAddr, .regRdEn, .regRdData, .regHit,
   .sampleValid, .sampleChannel, .eventClear, .eventFlag, .beyondState);

// File: verif/wdc_host_model.sv
`timescale 1ns/1ns
module wdc_host_model (
   input  wire logic        clk,
   input  wire logic [7:0]  regRdData,
   input  wire logic        regHit,
   output logic      [7:0]  regAddr,
   output logic      [7:0]  regWrData,
   output logic             regWrEn,
   output logic             regRdEn,
   output logic             sampleValid,
   output logic      [2:0]  sampleChannel,
   output logic      [11:0] sampleData,
   output logic      [1:0]  eventClear
);
   // ------------------------------
   // register and sample access
   // ------------------------------
   initial begin
      {regAddr, regWrData, regWrEn, regRdEn} = 18'h00000;
      {sampleValid, sampleChannel, sampleData, eventClear} = 18'h00000;
   end
   task automatic access(input logic wr, input logic [7:0] a, d,
                         output logic [7:0] q, output logic h);
      @(posedge clk);
      {regAddr, regWrData, regWrEn, regRdEn} <= {a, d, wr, !wr};
      @(posedge clk);
      {regWrEn, regRdEn} <= 2'b00;
      #1;
      q = regRdData;
      h = regHit;
   endtask : access
   task automatic sample(input logic [2:0] c, input logic [11:0] v);
      @(posedge clk);
      {sampleValid, sampleChannel, sampleData} <= {1'b1, c, v};
      @(posedge clk);
      sampleValid <= 1'b0;
      #1;
   endtask : sample
   task automatic clear(input logic [1:0] m);
      @(posedge clk);
      eventClear <= m;
      @(posedge clk);
      eventClear <= 2'b00;
      #1;
   endtask : clear
endmodule : wdc_host_model

// File: verif/wdc_limits_test.sv
`timescale 1ns/1ns
module wdc_limits_test;
   logic        clk, sys_rst, regWrEn, regRdEn, regHit, sampleValid, rh;
   logic [7:0]  regAddr, regWrData, regRdData, rq;
   logic [2:0]  sampleChannel;
   logic [11:0] sampleData;
   logic [1:0]  eventClear, eventFlag, beyondState;
   int          failures, samples_checked;
   wdc_limits dut_u (.clk, .sys_rst, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData,
      .regHit, .sampleValid, .sampleChannel, .sampleData, .eventClear, .eventFlag, .beyondState);
   wdc_host_model host_u (.clk, .regRdData, .regHit, .regAddr, .regWrData, .regWrEn, .regRdEn,
      .sampleValid, .sampleChannel, .sampleData, .eventClear);
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // ------------------------------
   // helpers
   // ------------------------------
   task automatic chk(input string n, input logic [11:0] e, g);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic complete_run;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : complete_run
   task automatic wr(input logic [7:0] a, d);
      host_u.access(1'b1, a, d, rq, rh);
   endtask : wr
   task automatic rd(input logic [7:0] a, e, input logic h);
      host_u.access(1'b0, a, 8'h00, rq, rh);
      chk("regRdData", e, rq);
      chk("regHit", h, rh);
   endtask : rd
   task automatic smp(input logic [2:0] c, input logic [11:0] v, input logic [1:0] b, f);
      host_u.sample(c, v);
      chk("beyondState", b, beyondState);
      chk("eventFlag", f, eventFlag);
   endtask : smp
   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      complete_run();
   end
   // ------------------------------
   // sequence
   // ------------------------------
   initial begin
      sys_rst = 1'b1;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 8; i++)
         rd(8'h34 + 8'(i), i % 4 == 0 ? 8'hf0 : i % 4 == 1 ? 8'hff : 8'h00, 1'b1);
      rd(8'h33, 8'h00, 1'b0);
      rd(8'h3c, 8'h00, 1'b0);
      for (int i = 0; i < 8; i++)
         wr(8'h34 + 8'(i), 8'h61 + 8'(i));
      for (int i = 0; i < 8; i++)
         rd(8'h34 + 8'(i), 8'h61 + 8'(i), 1'b1);
      wr(8'h33, 8'h5a);
      wr(8'h3c, 8'h5a);
      rd(8'h34, 8'h61, 1'b1);
      rd(8'h38, 8'h65, 1'b1);
      wr(8'h34, 8'h30);
      wr(8'h35, 8'h80);
      wr(8'h36, 8'h02);
      wr(8'h37, 8'h00);
      smp(3'h5, 12'h803, 2'b00, 2'b00);
      for (int i = 0; i < 3; i++)
         smp(3'h5, 12'h804, 2'b01, i == 2 ? 2'b01 : 2'b00);
      host_u.clear(2'b01);
      chk("eventFlag", 2'b00, eventFlag);
      wr(8'h34, 8'h32);
      smp(3'h5, 12'h7f4, 2'b01, 2'b01);
      smp(3'h5, 12'h7f3, 2'b00, 2'b01);
      wr(8'h38, 8'hf1);
      wr(8'h39, 8'hff);
      wr(8'h3a, 8'h50);
      wr(8'h3b, 8'h40);
      smp(3'h6, 12'h405, 2'b00, 2'b01);
      smp(3'h6, 12'h404, 2'b10, 2'b11);
      smp(3'h6, 12'h40c, 2'b10, 2'b11);
      smp(3'h7, 12'hfff, 2'b10, 2'b11);
      smp(3'h6, 12'h40d, 2'b00, 2'b11);
      fork
         host_u.sample(3'h6, 12'h404);
         host_u.clear(2'b10);
      join
      chk("eventFlag", 2'b11, eventFlag);
      host_u.clear(2'b10);
      chk("eventFlag", 2'b01, eventFlag);
      wr(8'h36, 8'h0f);
      host_u.clear(2'b01);
      for (int i = 0; i < 16; i++)
         smp(3'h5, 12'h900, 2'b11, i == 15 ? 2'b01 : 2'b00);
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rd(8'h38, 8'hf0, 1'b1);
      rd(8'h3b, 8'h00, 1'b1);
      chk("eventFlag", 2'b00, eventFlag);
      chk("beyondState", 2'b00, beyondState);
      complete_run();
   end
endmodule : wdc_limits_test
